// file: verilog/link_pkg.sv
// shared constants for the serial link control and status block
// assumes an APB master on pclk and one octet per lane symbol per cycle
package link_pkg;

    // register indices, byte address is four times the index
    localparam logic [11:0] PLL_STATUS_IDX   = 12'h56f;
    localparam logic [11:0] LINK_CTRL1_IDX   = 12'h571;
    localparam logic [15:0] PLL_STATUS_ADDR  = {2'b00, PLL_STATUS_IDX, 2'b00};
    localparam logic [15:0] LINK_CTRL1_ADDR  = {2'b00, LINK_CTRL1_IDX, 2'b00};

    // status register fields
    localparam int          LOCK_BIT         = 7;
    localparam int          LOSS_BIT         = 3;

    // first link control register fields
    localparam int          STBY_MODE_BIT    = 7;
    localparam int          TAIL_PN_BIT      = 6;
    localparam int          LONG_TEST_BIT    = 5;
    localparam int          LANE_SYNC_BIT    = 4;
    localparam int          ALIGN_MODE_LSB   = 2;
    localparam int          CHAR_INS_DIS_BIT = 1;
    localparam int          POWER_DOWN_BIT   = 0;
    localparam logic [7:0]  CTRL1_RESET      = 8'h14;

    // initial lane alignment modes
    localparam logic [1:0]  ALIGN_OFF        = 2'h0;
    localparam logic [1:0]  ALIGN_ONCE       = 2'h1;
    localparam logic [1:0]  ALIGN_LOOP       = 2'h3;

    // control characters (8b/10b k codes)
    localparam logic [7:0]  K_28_0           = 8'h1c;
    localparam logic [7:0]  K_28_3           = 8'h7c;
    localparam logic [7:0]  K_28_5           = 8'hbc;
    localparam logic [7:0]  K_28_7           = 8'hfc;

    // framing and buffering defaults
    localparam int          FRAME_OCTETS     = 2;
    localparam int          FRAMES_PER_MF    = 4;
    localparam int          ALIGN_MFS        = 4;
    localparam int          FIFO_DEPTH       = 8;
    localparam int          SAMPLE_W         = 8;

endpackage

// file: verilog/link_sync2.sv
// two flip-flop synchroniser for levels arriving from pins
// assumes the inputs are slow levels, not pulses shorter than a cycle
module link_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // first stage feeds the second stage only
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t s;      // registered state
    sync_st_t nxt_s;  // next state

    // next-state logic
    always_comb begin
        nxt_s    = s;
        nxt_s.s1 = din;
        nxt_s.s2 = s.s1;
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= nxt_s;
        end
    end

    assign dout = s.s2;

endmodule

// file: verilog/sample_fifo.sv
// small synchronous fifo between the converter samples and the lane
// assumes one clock; pushes and pops may happen in the same cycle
module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // refuse shapes the pointer logic cannot serve
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
        $error("sample_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
        logic [AW-1:0]               wr;    // write pointer
        logic [AW-1:0]               rd;    // read pointer
        logic [CW-1:0]               count; // words held
        logic                        full;  // registered so ready is a flop
    } fifo_st_t;

    fifo_st_t s;
    fifo_st_t nxt_s;
    logic     push;
    logic     pop;

    // pointer and count update
    always_comb begin
        nxt_s = s;
        push  = in_valid && !s.full;
        pop   = out_ready && (s.count != '0);
        if (push) begin
            nxt_s.mem[s.wr] = in_data;
            nxt_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : AW'(s.wr + 1'b1);
        end
        if (pop) begin
            nxt_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : AW'(s.rd + 1'b1);
        end
        // simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            nxt_s.count = CW'(s.count + 1'b1);
        end else if (pop && !push) begin
            nxt_s.count = CW'(s.count - 1'b1);
        end
        nxt_s.full = (nxt_s.count == CW'(DEPTH));
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= nxt_s;
        end
    end

    assign in_ready  = !s.full;
    assign out_valid = (s.count != '0);
    assign out_data  = s.mem[s.rd];

endmodule

// file: verilog/serial_link_ctrl_status.sv
// serial link control and status registers with the lane symbol source
// assumes an APB master on pclk, pins for lock and sync request
// Operation
// - loss of lock sets sticky status bit 3
// - only writing control bit 0 clears sticky bit
// - standby mode 0 sends zero samples
// - standby mode 1 sends K28.5 characters
// - bit 5 sends long transport test samples
// - bit 4 picks K28.3 plus K28.7 or K28.7
// - bits 3:2 omit, send once, or loop alignment
// - bit 1 zero enables alignment character insertion
// - bit 1 one disables character insertion, debug
// - bit 0 zero runs link, sync governs
// - bit 0 one holds link reset, clock gated
//
// Register access over APB is this design's own decision.
module serial_link_ctrl_status
    import link_pkg::*;
#(
    parameter int OCTETS  = FRAME_OCTETS,
    parameter int FRAMES  = FRAMES_PER_MF,
    parameter int ALIGNS  = ALIGN_MFS,
    parameter int DEPTH   = FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pll_locked,
    input  wire logic        sync_request_input_n,
    input  wire logic        standby,
    input  wire logic [7:0]  sample_data,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    output logic      [7:0]  lane_data,
    output logic             lane_is_k,
    output logic             lane_valid,
    output logic             link_rst_n,
    output logic             lane_clk_en
);

    localparam int OW = (OCTETS > 1) ? $clog2(OCTETS) : 1;
    localparam int FW = (FRAMES > 1) ? $clog2(FRAMES) : 1;
    localparam int MW = (ALIGNS > 1) ? $clog2(ALIGNS) : 1;

    // framing needs a first and a last octet and frame
    if (OCTETS < 2 || FRAMES < 2 || ALIGNS < 1) begin : g_bad_frame
        $error("serial_link_ctrl_status framing parameters too small");
    end

    typedef enum logic [1:0] {
        ST_OFF,    // link held in reset
        ST_CGS,    // code group synchronization
        ST_ALIGN,  // initial lane alignment multiframes
        ST_DATA    // user data frames
    } link_state_t;

    typedef struct packed {
        link_state_t   state;    // link layer state
        logic [7:0]    ctrl;     // first link control register
        logic          loss;     // sticky loss of lock
        logic          lock_q;   // lock one cycle ago, for edges
        logic [OW-1:0] oct;      // octet within frame
        logic [FW-1:0] frm;      // frame within multiframe
        logic [MW-1:0] mf;       // alignment multiframe count
        logic [7:0]    prev;     // last octet of previous frame
        logic [31:0]   prdata;   // read data
        logic          pready;   // access completes
        logic          pslverr;  // unmapped address
        logic [7:0]    lane_data;
        logic          lane_k;
        logic          lane_valid;
        logic          link_rst_n;
        logic          clk_en;
    } top_st_t;

    localparam top_st_t RESET_ST = '{state: ST_OFF, ctrl: CTRL1_RESET,
                                     default: '0};

    top_st_t     s;            // registered state
    top_st_t     nxt_s;        // next state
    logic [1:0]  pins_s;       // synchronised pins
    logic        lock_s;       // pll lock after synchroniser
    logic        sync_req;     // receiver asks for synchronization
    logic [7:0]  fifo_data;    // head sample
    logic        fifo_valid;   // head sample present
    logic        fifo_ready;   // lane consumes the head
    logic        hit_pll;      // address hits status
    logic        hit_ctl;      // address hits control
    logic        rd_pll;       // status read being answered
    logic        clr_loss;     // write of one to control bit 0
    logic        emit;         // a symbol goes out this cycle
    logic [7:0]  sym;          // symbol value
    logic        sym_k;        // symbol is a control character
    logic [7:0]  raw;          // data octet before insertion
    logic [7:0]  test_val;     // long transport test sample
    logic        last_oct;
    logic        last_frm;
    logic [1:0]  amode;        // alignment mode field
    logic        stby_cgs;     // standby asks for K28.5

    // both pins are asynchronous levels
    link_sync2 #(
        .W (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({pll_locked, sync_request_input_n}),
        .dout    (pins_s)
    );

    assign lock_s   = pins_s[1];
    assign sync_req = !pins_s[0];

    sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // data frames drain the buffer; test and zero modes discard samples
    assign fifo_ready = (s.state == ST_DATA);

    assign hit_pll  = (paddr == PLL_STATUS_ADDR);
    assign hit_ctl  = (paddr == LINK_CTRL1_ADDR);
    assign rd_pll   = psel && penable && !s.pready && !pwrite && hit_pll;
    assign clr_loss = psel && penable && s.pready && pwrite && hit_ctl &&
                      pstrb[0] && pwdata[POWER_DOWN_BIT];
    assign amode    = s.ctrl[ALIGN_MODE_LSB +: 2];
    assign stby_cgs = standby && s.ctrl[STBY_MODE_BIT];
    assign last_oct = (s.oct == OW'(OCTETS - 1));
    assign last_frm = (s.frm == FW'(FRAMES - 1));
    assign test_val = 8'(int'(s.frm) * OCTETS + int'(s.oct));

    // registers, sticky flag, link sequencing and lane symbol
    always_comb begin
        nxt_s        = s;
        nxt_s.lock_q = lock_s;
        emit         = 1'b0;
        sym          = 8'h00;
        sym_k        = 1'b0;
        raw          = 8'h00;

        // first access cycle loads the answer, second completes it
        nxt_s.pready = 1'b0;
        if (psel && penable && !s.pready) begin
            nxt_s.pready  = 1'b1;
            nxt_s.pslverr = !(hit_pll || hit_ctl);
            nxt_s.prdata  = 32'h0000_0000;
            if (!pwrite && hit_pll) begin
                nxt_s.prdata[LOCK_BIT] = lock_s;
                nxt_s.prdata[LOSS_BIT] = s.loss;
            end else if (!pwrite && hit_ctl) begin
                nxt_s.prdata[7:0] = s.ctrl;
            end
        end
        // a write lands on the edge where the master sees pready
        if (psel && penable && s.pready && pwrite && hit_ctl && pstrb[0]) begin
            nxt_s.ctrl = pwdata[7:0];
        end

        // set wins over clear so no loss event is dropped
        if (clr_loss) begin
            nxt_s.loss = 1'b0;
        end
        if (s.lock_q && !lock_s) begin
            nxt_s.loss = 1'b1;
        end

        // symbol for the current state
        case (s.state)
            ST_OFF: begin
                emit = 1'b0;
            end
            ST_CGS: begin
                emit  = 1'b1;
                sym   = K_28_5;
                sym_k = 1'b1;
            end
            ST_ALIGN: begin
                emit = 1'b1;
                if (s.oct == '0 && s.frm == '0) begin
                    sym   = K_28_0;
                    sym_k = 1'b1;
                end else if (last_oct && last_frm) begin
                    sym   = K_28_3;
                    sym_k = 1'b1;
                end else begin
                    sym = 8'(s.oct);
                end
            end
            ST_DATA: begin
                if (s.ctrl[LONG_TEST_BIT]) begin
                    emit = 1'b1;
                    raw  = test_val;
                end else if (standby && !s.ctrl[STBY_MODE_BIT]) begin
                    emit = 1'b1;
                    raw  = 8'h00;
                end else if (fifo_valid) begin
                    emit = 1'b1;
                    raw  = fifo_data;
                end
                sym = raw;
                // repeated frame end octet becomes an alignment character
                if (last_oct && !s.ctrl[CHAR_INS_DIS_BIT] &&
                    raw == s.prev) begin
                    sym_k = 1'b1;
                    if (last_frm && s.ctrl[LANE_SYNC_BIT]) begin
                        sym = K_28_3;
                    end else begin
                        sym = K_28_7;
                    end
                end
            end
            default: begin
                emit = 1'b0;
            end
        endcase

        // framing counters advance only with a symbol; an empty
        // buffer stalls the frame instead of inventing data
        if (emit && (s.state == ST_ALIGN || s.state == ST_DATA)) begin
            if (last_oct) begin
                nxt_s.oct = '0;
                nxt_s.frm = last_frm ? '0 : FW'(s.frm + 1'b1);
                if (s.state == ST_DATA) begin
                    nxt_s.prev = raw;
                end
            end else begin
                nxt_s.oct = OW'(s.oct + 1'b1);
            end
        end

        // state sequencing, power down has the highest priority
        if (s.ctrl[POWER_DOWN_BIT]) begin
            nxt_s.state = ST_OFF;
        end else if (s.state == ST_OFF || sync_req || stby_cgs) begin
            nxt_s.state = ST_CGS;
            nxt_s.oct   = '0;
            nxt_s.frm   = '0;
            nxt_s.mf    = '0;
            nxt_s.prev  = 8'h00;
        end else begin
            case (s.state)
                ST_CGS: begin
                    // mode 10 is undefined and treated as send once
                    if (amode == ALIGN_OFF) begin
                        nxt_s.state = ST_DATA;
                    end else begin
                        nxt_s.state = ST_ALIGN;
                    end
                end
                ST_ALIGN: begin
                    if (emit && last_oct && last_frm) begin
                        if (amode == ALIGN_LOOP) begin
                            nxt_s.mf = '0;
                        end else if (s.mf == MW'(ALIGNS - 1)) begin
                            nxt_s.state = ST_DATA;
                        end else begin
                            nxt_s.mf = MW'(s.mf + 1'b1);
                        end
                    end
                end
                default: begin
                    nxt_s.state = s.state;
                end
            endcase
        end

        // registered lane outputs, link reset follows control bit 0
        nxt_s.lane_valid = emit;
        nxt_s.lane_data  = sym;
        nxt_s.lane_k     = sym_k;
        nxt_s.link_rst_n = !s.ctrl[POWER_DOWN_BIT];
        nxt_s.clk_en     = !s.ctrl[POWER_DOWN_BIT];
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RESET_ST;
        end else begin
            s <= nxt_s;
        end
    end

    assign prdata      = s.prdata;
    assign pready      = s.pready;
    assign pslverr     = s.pslverr;
    assign lane_data   = s.lane_data;
    assign lane_is_k   = s.lane_k;
    assign lane_valid  = s.lane_valid;
    assign link_rst_n  = s.link_rst_n;
    assign lane_clk_en = s.clk_en;

    property p_lock_read;
        @(posedge pclk) disable iff (!presetn)
        rd_pll |=> (s.prdata[LOCK_BIT] == $past(lock_s)) && s.pready;
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit read does not match pll lock");

    property p_loss_set;
        @(posedge pclk) disable iff (!presetn)
        $fell(lock_s) |=> s.loss ##1 (s.loss || $past(clr_loss));
    endproperty
    a_loss_set: assert property (p_loss_set)
        else $error("loss of lock not captured");

    property p_loss_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(s.loss) |-> $past(clr_loss);
    endproperty
    a_loss_clear: assert property (p_loss_clear)
        else $error("sticky loss cleared without a write");

    property p_standby_zero;
        @(posedge pclk) disable iff (!presetn)
        (s.state == ST_DATA && standby && !s.ctrl[STBY_MODE_BIT] &&
         !s.ctrl[LONG_TEST_BIT])
        |=> lane_valid && (lane_is_k || lane_data == 8'h00);
    endproperty
    a_standby_zero: assert property (p_standby_zero)
        else $error("standby did not send zero samples");

    property p_standby_cgs;
        @(posedge pclk) disable iff (!presetn)
        (stby_cgs && !s.ctrl[POWER_DOWN_BIT])
        |=> s.state == ST_CGS ##1 (lane_is_k && lane_data == K_28_5);
    endproperty
    a_standby_cgs: assert property (p_standby_cgs)
        else $error("standby did not force K28.5");

    property p_long_test;
        @(posedge pclk) disable iff (!presetn)
        (s.state == ST_DATA && s.ctrl[LONG_TEST_BIT])
        |=> lane_valid && (lane_is_k || lane_data == $past(test_val));
    endproperty
    a_long_test: assert property (p_long_test)
        else $error("long transport test sample wrong");

    property p_k283_needs_sync;
        @(posedge pclk) disable iff (!presetn)
        ($past(s.state) == ST_DATA && lane_is_k && lane_data == K_28_3)
        |-> $past(s.ctrl[LANE_SYNC_BIT]);
    endproperty
    a_k283_needs_sync: assert property (p_k283_needs_sync)
        else $error("K28.3 inserted while lane sync is off");

    property p_align_skip;
        @(posedge pclk) disable iff (!presetn)
        ($past(s.state) == ST_CGS && s.state == ST_ALIGN)
        |-> $past(amode) != ALIGN_OFF;
    endproperty
    a_align_skip: assert property (p_align_skip)
        else $error("alignment sent while disabled");

    property p_no_insert;
        @(posedge pclk) disable iff (!presetn)
        (s.state == ST_DATA && s.ctrl[CHAR_INS_DIS_BIT]) |=> !lane_is_k;
    endproperty
    a_no_insert: assert property (p_no_insert)
        else $error("character inserted while disabled");

    property p_power_down;
        @(posedge pclk) disable iff (!presetn)
        s.ctrl[POWER_DOWN_BIT]
        |=> (s.state == ST_OFF) && !link_rst_n && !lane_clk_en;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("link not held in reset at power down");

endmodule

// file: testbench/link_rx_model.sv
// receiver model for the far end of the serial lane
// assumes lane symbols arrive one octet per pclk cycle
module link_rx_model
    import link_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] lane_data,
    input  wire logic       lane_is_k,
    input  wire logic       lane_valid,
    input  wire logic       link_rst_n,
    output logic            sync_request_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int run;  // consecutive sync characters seen

    // request sync until four sync characters in a row arrive;
    // a link held in reset restarts the request, as a real receiver would
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !link_rst_n) begin
            sync_request_input_n <= 1'b0;
            run <= 0;
        end else if (lane_valid && lane_is_k && lane_data == K_28_5) begin
            run <= run + 1;
            if (run >= 3) begin
                sync_request_input_n <= 1'b1;
            end
        end else if (!sync_request_input_n) begin
            run <= 0;  // a broken run does not count
        end
    end
endmodule

// file: testbench/tb_serial_link_ctrl_status.sv
// bench for the serial link control and status block
// assumes the receiver model answers the sync requests
module tb_serial_link_ctrl_status
    import link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic        pll_locked, sync_n, standby, sample_valid, sample_ready;
    logic [7:0]  sample_data, lane_data, prv;
    logic        lane_is_k, lane_valid, link_rst_n, lane_clk_en, e, pv;
    int          failures, checked, cyc, k0, k3, k5, k7, nk, nz, bad;

    serial_link_ctrl_status uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_locked(pll_locked),
        .sync_request_input_n(sync_n), .standby(standby),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .lane_data(lane_data),
        .lane_is_k(lane_is_k), .lane_valid(lane_valid),
        .link_rst_n(link_rst_n), .lane_clk_en(lane_clk_en));
    link_rx_model rx (.pclk(pclk), .presetn(presetn),
        .lane_data(lane_data), .lane_is_k(lane_is_k),
        .lane_valid(lane_valid), .link_rst_n(link_rst_n),
        .sync_request_input_n(sync_n));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, y);
        checked++;
        if (y !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, x, y);
        end
    endtask

    // one apb transfer; waits on pready, only the run ceiling ends a hang
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk("register", {24'h0, x}, r);
    endtask

    // restart the link in a mode, then watch a window of symbols
    task automatic watch;
        @(negedge pclk);
        {k0, k3, k5, k7, nk, nz, bad, pv} = '0;
        repeat (120) @(posedge pclk);
    endtask
    task automatic mode(input logic [7:0] d, input logic sb);
        apb(1'b1, LINK_CTRL1_ADDR, d | 8'h01);
        standby <= sb;
        apb(1'b1, LINK_CTRL1_ADDR, d);
        watch();
    endtask

    // lane symbol monitor and run ceiling
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
        if (lane_valid === 1'b1 && lane_is_k === 1'b1) begin
            k0 += int'(lane_data == K_28_0);
            k3 += int'(lane_data == K_28_3);
            k5 += int'(lane_data == K_28_5);
            k7 += int'(lane_data == K_28_7);
            pv = 1'b0;
        end else if (lane_valid === 1'b1) begin
            nk++;
            nz += int'(lane_data != 8'h00);
            if (pv && lane_data !== ((prv + 8'h01) & 8'h07)) bad++;
            prv = lane_data;
            pv = 1'b1;
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, standby} = '0;
        {paddr, pwdata, prv, pv} = '0;
        {pstrb, pll_locked, sample_valid, sample_data} = {4'hf, 2'b11, 8'h55};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(PLL_STATUS_ADDR, 8'h80);
        rd(LINK_CTRL1_ADDR, 8'h14);
        apb(1'b1, PLL_STATUS_ADDR, 8'hff);
        rd(PLL_STATUS_ADDR, 8'h80);
        apb(1'b0, 16'h1000, 8'h00);
        chk("unmapped error", 1, e);
        pll_locked <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(PLL_STATUS_ADDR, 8'h08);
        pll_locked <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(PLL_STATUS_ADDR, 8'h88);
        apb(1'b1, LINK_CTRL1_ADDR, 8'h15);
        repeat (12) @(posedge pclk);
        chk("link_rst_n", 0, link_rst_n);
        chk("lane_clk_en", 0, lane_clk_en);
        chk("sample_ready full", 0, sample_ready);
        rd(PLL_STATUS_ADDR, 8'h80);
        mode(8'h10, 1'b0);
        chk("link_rst_n", 1, link_rst_n);
        chk("k28_3 seen", 1, k3 > 0);
        chk("k28_7 seen", 1, k7 > 0);
        mode(8'h00, 1'b0);
        chk("k28_3 seen", 0, k3 > 0);
        chk("k28_7 seen", 1, k7 > 0);
        chk("test order broken", 1, bad > 0);
        chk("k28_0 seen", 0, k0 > 0);
        mode(8'h02, 1'b0);
        chk("align chars", 0, k3 + k7);
        chk("data seen", 1, nk > 0);
        sample_valid <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("lane_valid starved", 0, lane_valid);
        sample_valid <= 1'b1;
        mode(8'h04, 1'b0);
        chk("k28_0 seen", 1, k0 > 0);
        watch();
        chk("k28_0 again", 0, k0 > 0);
        mode(8'h0c, 1'b0);
        watch();
        chk("k28_0 again", 1, k0 > 0);
        mode(8'h20, 1'b0);
        chk("test order broken", 0, bad);
        chk("test samples", 1, nk > 0);
        mode(8'h94, 1'b1);
        chk("k28_5 seen", 1, k5 > 0);
        chk("samples", 0, nk);
        mode(8'h02, 1'b1);
        chk("nonzero samples", 0, nz);
        chk("samples", 1, nk > 0);
        tally_and_finish();
    end
endmodule
